// >>> logic/boot_defines.svh
// Constants for the boot strap and address decode block.
// Assumes a 25 MHz system clock on CLK and an active-low reset NRST.
//
// Operation
// - Configuration pins are sampled once at power-up, then frozen.
// - Download pin low selects boot ROM download; high boots the application.
// - Normal-select pin low enters test mode using four test config pins.
// - Supply strap high selects switching regulator, low selects linear.
// - While external reset is held, general pins keep their previous state.
// - On reset release pins take defaults; fuse bits set their pulls.
// - Logic starts after 6ms; pin defaults follow 300us to 1.5ms later.
// - Firmware mode pins are made pulled-up inputs before they are sampled.
// - Boot high gives Normal; boot low picks test by status pin.
// - Radio test mode exchanges test commands over the logging serial port.
// - Factory check mode sends test data over the low-power serial port.
// - Instruction ROM at 0x0000_0000 (128KB), data ROM at 0x0002_0000 (32KB).
// - Small-core SRAM 0x0008_0000 (64KB); retention window 0x000C_0000.
// - 0x0200_0000 to 0x07FF_FFFF is PSRAM; 0x0800_0000 to 0x0FFF_FFFF flash.
// - Main SRAM 0x1000_0000 512KB; extension banks 0x100E_0000, 0x100F_0000.
// - 128MB peripheral windows at 0x4000_0000, 0x4800_0000, 0x5000_0000.
// - Embedded SRAMs accept byte, halfword and word accesses.
// - Main SRAM is two separately ported 256KB blocks.
// - SRAM forms three power domains of 256KB, 128KB and 128KB.
// - 1KB retention SRAM keeps data in deep sleep, reachable by both cores.
// - Without low-energy radio, an extra 64KB SRAM is available.
`ifndef BOOT_DEFINES_SVH
`define BOOT_DEFINES_SVH

`define IROM_BASE 32'h0000_0000
`define IROM_SIZE 32'h0002_0000
`define DROM_BASE 32'h0002_0000
`define DROM_SIZE 32'h0000_8000
`define LSRAM_BASE 32'h0008_0000
`define LSRAM_SIZE 32'h0001_0000
`define RET_BASE 32'h000C_0000
`define RET_SIZE 32'h0000_4000
`define RET_REAL 32'h0000_0400
`define PSRAM_BASE 32'h0200_0000
`define PSRAM_TOP 32'h07FF_FFFF
`define FLASH_BASE 32'h0800_0000
`define FLASH_TOP 32'h0FFF_FFFF
`define MSRAM_BASE 32'h1000_0000
`define MSRAM_SIZE 32'h0008_0000
`define MSRAM_HALF 32'h0004_0000
`define PD1_SIZE 32'h0004_0000
`define PD2_SIZE 32'h0002_0000
`define EXT0_BASE 32'h100E_0000
`define EXT1_BASE 32'h100F_0000
`define EXT_SIZE 32'h0001_0000
`define PERH_BASE 32'h4000_0000
`define PERL_BASE 32'h4800_0000
`define PERS_BASE 32'h5000_0000
`define PER_SIZE 32'h0800_0000

`define SUPPLY_MS 6
`define PIN_MIN_US 300
`define PIN_MAX_US 1500
`define CLK_MHZ 25
`define SUPPLY_CYC (`SUPPLY_MS * 1000 * `CLK_MHZ)
`define PIN_MIN_CYC (`PIN_MIN_US * `CLK_MHZ)
`define PIN_MAX_CYC (`PIN_MAX_US * `CLK_MHZ)
`define SYNC_FILL_CYC 3
`define FW_FILL_CYC 4

`define NPINS 16
`define NFUSE 5
`define PIN_DEFAULT_PULL 16'h0000

`endif

// >>> logic/boot_pkg.sv
// Types shared by the boot strap and address decode block.
// Assumes the defines header is compiled alongside.
`default_nettype none
package boot_pkg;
	typedef enum logic [3:0] {
		FW_NORMAL = 4'h1,
		FW_RADIO_TEST = 4'h2,
		FW_FACTORY = 4'h4,
		FW_NONE = 4'h8
	} fw_mode_e;

	typedef enum logic [4:0] {
		ST_SUPPLY = 5'h01,
		ST_STRAP = 5'h02,
		ST_SETTLE = 5'h04,
		ST_FW_PULL = 5'h08,
		ST_RUN = 5'h10
	} boot_state_e;

	typedef enum logic [3:0] {
		TGT_NONE = 4'h0,
		TGT_IROM = 4'h1,
		TGT_DROM = 4'h2,
		TGT_LSRAM = 4'h3,
		TGT_RET = 4'h4,
		TGT_PSRAM = 4'h5,
		TGT_FLASH = 4'h6,
		TGT_MSRAM0 = 4'h7,
		TGT_MSRAM1 = 4'h8,
		TGT_EXT0 = 4'h9,
		TGT_EXT1 = 4'hA,
		TGT_PERH = 4'hB,
		TGT_PERL = 4'hC,
		TGT_PERS = 4'hD
	} target_e;

	typedef struct packed {
		logic download;
		logic test_mode;
		logic [3:0] test_cfg;
		logic switching_regulator_mode;
		logic linear_regulator_mode;
	} strap_s;

	typedef struct packed {
		logic valid;
		logic [31:0] addr;
		logic [1:0] size;
	} bus_req_s;

	typedef struct packed {
		target_e target;
		logic error;
		logic [3:0] byte_en;
		logic [2:0] pd_hit;
	} bus_rsp_s;
endpackage
`default_nettype wire

// >>> logic/boot_decode.sv
// Power-up strap capture, firmware mode sampling, pin default control
// and system address decode.
// Assumes pins arrive asynchronously and a bus master drives one request
// per cycle on each of two ports (processor and DMA).
`include "boot_defines.svh"
`default_nettype none
module boot_decode
	import boot_pkg::*;
#(
	parameter int SUPPLY_CYC = `SUPPLY_CYC,
	parameter int PIN_MIN_CYC = `PIN_MIN_CYC,
	parameter int PIN_MAX_CYC = `PIN_MAX_CYC
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic NRST,
	// External reset pin, active low
	input wire logic EXT_RESET_N,
	// Pin inputs
	input wire logic [`NPINS-1:0] PIN_IN,
	input wire logic DOWNLOAD_STRAP,
	input wire logic NORMAL_SEL_STRAP,
	input wire logic SUPPLY_SELECT_STRAP,
	input wire logic [3:0] TEST_CONFIG,
	input wire logic FIRMWARE_BOOT_PIN,
	input wire logic FIRMWARE_STATUS_PIN,
	// Fuse pull control and radio use
	input wire logic [`NFUSE-1:0] FUSE_CONTROLLED_PULL,
	input wire logic BLE_UNUSED,
	// Pin drive
	output logic [`NPINS-1:0] PIN_OUT,
	output logic [`NPINS-1:0] PIN_OE,
	output logic [`NPINS-1:0] PIN_PULLUP,
	output logic FW_PULLUP,
	// Boot status
	output strap_s STRAPS,
	output fw_mode_e FW_MODE,
	output logic LOG_PORT_TEST_EN,
	output logic LP_PORT_FACTORY_EN,
	output logic LOGIC_READY,
	output logic PINS_READY,
	// Two bus ports
	input wire bus_req_s REQ0,
	input wire bus_req_s REQ1,
	output bus_rsp_s RSP0,
	output bus_rsp_s RSP1,
	output logic SAME_BANK_STALL
);

	// ******************************
	// Input synchronisers
	// ******************************
	localparam int NS = 6;
	logic [NS-1:0] raw;
	logic [NS-1:0] s1_reg, s2_reg, s3_reg, sync_reg;
	assign raw = {EXT_RESET_N, DOWNLOAD_STRAP, NORMAL_SEL_STRAP,
		SUPPLY_SELECT_STRAP, FIRMWARE_BOOT_PIN, FIRMWARE_STATUS_PIN};
	logic [3:0] c1_reg, c2_reg, c3_reg, cfg_reg;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			s1_reg <= '1;
			s2_reg <= '1;
			s3_reg <= '1;
			sync_reg <= '1;
			c1_reg <= 4'h0;
			c2_reg <= 4'h0;
			c3_reg <= 4'h0;
			cfg_reg <= 4'h0;
		end else begin
			s1_reg <= raw;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			sync_reg <= (s2_reg & s3_reg) | (sync_reg & (s2_reg | s3_reg));
			c1_reg <= TEST_CONFIG;
			c2_reg <= c1_reg;
			c3_reg <= c2_reg;
			cfg_reg <= (c2_reg & c3_reg) | (cfg_reg & (c2_reg | c3_reg));
		end
	end

	wire ext_rst_n = sync_reg[5];
	wire dl_s = sync_reg[4];
	wire nsel_s = sync_reg[3];
	wire sps_s = sync_reg[2];
	wire boot_s = sync_reg[1];
	wire stat_s = sync_reg[0];

	// ******************************
	// Power-up sequence
	// ******************************
	boot_state_e state_reg, state_next;
	logic [31:0] cnt_reg, cnt_next;
	wire sup_done = cnt_reg >= 32'(SUPPLY_CYC - 1);
	wire pin_done = cnt_reg >= 32'(PIN_MIN_CYC - 1);
	wire sync_done = cnt_reg >= 32'(`SYNC_FILL_CYC);
	// Pull-up reaches the pin only after FW_PULLUP rises: one cycle more
	wire fw_done = cnt_reg >= 32'(`FW_FILL_CYC);

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg + 32'h1;
		case (state_reg)
			ST_SUPPLY: begin
				if (sup_done) begin
					state_next = ST_STRAP;
					cnt_next = 32'h0;
				end
			end
			ST_STRAP: begin
				// Wait for synchronisers to fill before latching
				if (sync_done) begin
					state_next = ST_SETTLE;
					cnt_next = 32'h0;
				end
			end
			ST_SETTLE: begin
				if (pin_done) begin
					state_next = ST_FW_PULL;
					cnt_next = 32'h0;
				end
			end
			ST_FW_PULL: begin
				if (fw_done) begin
					state_next = ST_RUN;
					cnt_next = 32'h0;
				end
			end
			ST_RUN: cnt_next = cnt_reg;
			default: state_next = ST_SUPPLY;
		endcase
	end

	// ******************************
	// Strap latch, once per power-up
	// ******************************
	strap_s straps_reg;
	logic latched_reg;
	wire take_strap = (state_reg == ST_STRAP) && sync_done && !latched_reg;

	// Firmware mode decode
	fw_mode_e fw_dec;
	assign fw_dec = boot_s ? FW_NORMAL :
		(stat_s ? FW_RADIO_TEST : FW_FACTORY);
	fw_mode_e fw_reg;
	wire take_fw = (state_reg == ST_FW_PULL) && fw_done;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			state_reg <= ST_SUPPLY;
			cnt_reg <= 32'h0;
			latched_reg <= 1'b0;
			straps_reg <= '0;
			fw_reg <= FW_NONE;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			if (take_strap) begin
				latched_reg <= 1'b1;
				straps_reg.download <= !dl_s;
				straps_reg.test_mode <= !nsel_s;
				straps_reg.test_cfg <= nsel_s ? 4'h0 : cfg_reg;
				straps_reg.switching_regulator_mode <= sps_s;
				straps_reg.linear_regulator_mode <= !sps_s;
			end
			if (take_fw) begin
				fw_reg <= fw_dec;
			end
		end
	end

	// ******************************
	// Pin hold and defaults
	// ******************************
	// Fuse-controlled pulls sit on the low pins; the rest default to
	// input with the fixed pull pattern.
	logic [`NPINS-1:0] dflt_pull;
	localparam logic [`NPINS-1:0] DFLT_PULL = `PIN_DEFAULT_PULL;
	genvar g;
	generate
		for (g = 0; g < `NPINS; g++) begin : g_pull
			if (g < `NFUSE) begin : g_f
				assign dflt_pull[g] = FUSE_CONTROLLED_PULL[g];
			end else begin : g_p
				assign dflt_pull[g] = DFLT_PULL[g];
			end
		end
	endgenerate

	logic [`NPINS-1:0] pout_reg, poe_reg, ppu_reg;
	wire pins_live = (state_reg == ST_FW_PULL) || (state_reg == ST_RUN);
	wire rst_fall = !ext_rst_n;

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			pout_reg <= '0;
			poe_reg <= '0;
			ppu_reg <= '0;
		end else if (rst_fall) begin
			// Keep prior state while the reset button is held
			pout_reg <= pout_reg;
			poe_reg <= poe_reg;
			ppu_reg <= ppu_reg;
		end else if (pins_live) begin
			// Defaults; software muxing lives outside this block
			pout_reg <= '0;
			poe_reg <= '0;
			ppu_reg <= dflt_pull;
		end
	end

	// ******************************
	// Address decode
	// ******************************
	function automatic logic in_win(input logic [31:0] a,
		input logic [31:0] base, input logic [31:0] size);
		in_win = (a >= base) && (a - base < size);
	endfunction

	function automatic bus_rsp_s decode(input bus_req_s r,
		input logic ble_off);
		logic [31:0] a;
		logic [1:0] o;
		a = r.addr;
		o = r.addr[1:0];
		decode = '0;
		if (in_win(a, `IROM_BASE, `IROM_SIZE)) begin
			decode.target = TGT_IROM;
		end else if (in_win(a, `DROM_BASE, `DROM_SIZE)) begin
			decode.target = TGT_DROM;
		end else if (in_win(a, `LSRAM_BASE, `LSRAM_SIZE)) begin
			decode.target = TGT_LSRAM;
		end else if (in_win(a, `RET_BASE, `RET_REAL)) begin
			decode.target = TGT_RET;
		end else if (a >= `PSRAM_BASE && a <= `PSRAM_TOP) begin
			decode.target = TGT_PSRAM;
		end else if (a >= `FLASH_BASE && a <= `FLASH_TOP) begin
			decode.target = TGT_FLASH;
		end else if (in_win(a, `MSRAM_BASE, `MSRAM_HALF)) begin
			decode.target = TGT_MSRAM0;
		end else if (in_win(a, `MSRAM_BASE + `MSRAM_HALF, `MSRAM_HALF)) begin
			decode.target = TGT_MSRAM1;
		end else if (ble_off && in_win(a, `EXT0_BASE, `EXT_SIZE)) begin
			decode.target = TGT_EXT0;
		end else if (in_win(a, `EXT1_BASE, `EXT_SIZE)) begin
			decode.target = TGT_EXT1;
		end else if (in_win(a, `PERH_BASE, `PER_SIZE)) begin
			decode.target = TGT_PERH;
		end else if (in_win(a, `PERL_BASE, `PER_SIZE)) begin
			decode.target = TGT_PERL;
		end else if (in_win(a, `PERS_BASE, `PER_SIZE)) begin
			decode.target = TGT_PERS;
		end
		// Unaligned or oversize accesses are refused too
		if (decode.target == TGT_NONE || r.size == 2'b11 ||
			(r.size == 2'b01 && o[0]) || (r.size == 2'b10 && o != 2'b00)) begin
			decode.target = TGT_NONE;
			decode.error = r.valid;
		end else begin
			case (r.size)
				2'b00: decode.byte_en = 4'b0001 << o;
				2'b01: decode.byte_en = o[1] ? 4'b1100 : 4'b0011;
				default: decode.byte_en = 4'b1111;
			endcase
			if (!r.valid) begin
				decode.byte_en = 4'h0;
			end
		end
		// Power domains: main SRAM splits 256KB, 128KB, 128KB
		if (decode.target == TGT_MSRAM0 || decode.target == TGT_MSRAM1) begin
			if (a - `MSRAM_BASE < `PD1_SIZE) begin
				decode.pd_hit = 3'b001;
			end else if (a - `MSRAM_BASE < `PD1_SIZE + `PD2_SIZE) begin
				decode.pd_hit = 3'b010;
			end else begin
				decode.pd_hit = 3'b100;
			end
		end
	endfunction

	bus_rsp_s dec0, dec1;
	assign dec0 = decode(REQ0, BLE_UNUSED);
	assign dec1 = decode(REQ1, BLE_UNUSED);
	// Only a clash on the same block stalls the second port
	wire clash = REQ0.valid && REQ1.valid && dec0.target == dec1.target &&
		dec0.target != TGT_NONE;

	bus_rsp_s rsp0_reg, rsp1_reg;
	logic stall_reg;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rsp0_reg <= '0;
			rsp1_reg <= '0;
			stall_reg <= 1'b0;
		end else begin
			rsp0_reg <= dec0;
			rsp1_reg <= clash ? bus_rsp_s'('0) : dec1;
			stall_reg <= clash;
		end
	end

	// ******************************
	// Outputs
	// ******************************
	logic fw_pu_reg, log_reg, lp_reg, prdy_reg;
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			fw_pu_reg <= 1'b0;
			log_reg <= 1'b0;
			lp_reg <= 1'b0;
			prdy_reg <= 1'b0;
		end else begin
			// Ready follows pins_live on the same edge as the first default write; an external reset hold does not delay it
			prdy_reg <= pins_live;
			fw_pu_reg <= state_next == ST_FW_PULL;
			log_reg <= fw_reg == FW_RADIO_TEST;
			lp_reg <= fw_reg == FW_FACTORY;
		end
	end

	assign PIN_OUT = pout_reg;
	assign PIN_OE = poe_reg;
	assign PIN_PULLUP = ppu_reg;
	assign FW_PULLUP = fw_pu_reg;
	assign STRAPS = straps_reg;
	assign FW_MODE = fw_reg;
	assign LOG_PORT_TEST_EN = log_reg;
	assign LP_PORT_FACTORY_EN = lp_reg;
	assign LOGIC_READY = latched_reg;
	assign PINS_READY = prdy_reg;
	assign RSP0 = rsp0_reg;
	assign RSP1 = rsp1_reg;
	assign SAME_BANK_STALL = stall_reg;

endmodule
`default_nettype wire

// >>> testbench/strap_board.sv
// Board model: strap jumpers with pull-ups and the firmware mode pins.
// Assumes the bench drives it off the falling edge of clk.
`default_nettype none
module strap_board (
	// Clock for the floating-line pattern
	input wire logic clk,
	// Jumper to ground per strap: download, normal select, supply
	input wire logic [2:0] gnd,
	// Firmware pins: driven flag, level, on-chip pull-up
	input wire logic [1:0] drv,
	input wire logic [1:0] lvl,
	input wire logic fw_pullup,
	// Levels seen by the device
	output logic download,
	output logic normal_sel,
	output logic supply_sel,
	output logic [1:0] fw_pins
);
	logic float_reg = 1'b0;
	always @(posedge clk) float_reg <= ~float_reg;
	assign download = ~gnd[0];
	assign normal_sel = ~gnd[1];
	assign supply_sel = ~gnd[2];
	// An unpulled, undriven pin wanders, so it never reads as a fixed level
	assign fw_pins[0] = drv[0] ? lvl[0] : (fw_pullup | float_reg);
	assign fw_pins[1] = drv[1] ? lvl[1] : (fw_pullup | float_reg);
endmodule
`default_nettype wire

// >>> testbench/boot_decode_props.sv
// Port assertions for the boot strap and address decode block.
// Bound onto boot_decode; sees only its ports, clocked by CLK.
`include "boot_defines.svh"
`default_nettype none
module boot_decode_props
	import boot_pkg::*;
(
	// Clock, resets and pins
	input wire logic CLK,
	input wire logic NRST,
	input wire logic EXT_RESET_N,
	input wire logic [`NFUSE-1:0] FUSE_CONTROLLED_PULL,
	input wire logic [`NPINS-1:0] PIN_OUT,
	input wire logic [`NPINS-1:0] PIN_OE,
	input wire logic [`NPINS-1:0] PIN_PULLUP,
	// Boot status
	input wire strap_s STRAPS,
	input wire fw_mode_e FW_MODE,
	input wire logic LOG_PORT_TEST_EN,
	input wire logic LP_PORT_FACTORY_EN,
	input wire logic LOGIC_READY,
	input wire logic PINS_READY,
	// Bus ports
	input wire bus_req_s REQ0,
	input wire bus_req_s REQ1,
	input wire bus_rsp_s RSP0,
	input wire bus_rsp_s RSP1,
	input wire logic SAME_BANK_STALL
);
	// ********
	// Checks
	// ********
	wire logic [31:0] a0 = REQ0.addr;
	wire logic hi0 = REQ0.addr[18];
	wire logic w0 = REQ0.valid && REQ0.size == 2'h2 && a0[1:0] == 2'h0;
	wire logic ms0 = w0 && a0[31:19] == 13'h0200;
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);

	a_psram_route: assert property (w0 && a0 >= 32'h0200_0000
		&& a0 <= 32'h07FF_FFFF |=> RSP0.target == TGT_PSRAM)
		else $error("psram window misdecoded");
	a_flash_route: assert property (w0 && a0[31:27] == 5'h01
		|=> RSP0.target == TGT_FLASH && !RSP0.error)
		else $error("flash window misdecoded");
	a_periph_route: assert property (w0 && a0[31:27] == 5'h08
		|=> RSP0.target == TGT_PERH)
		else $error("peripheral window misdecoded");
	a_rsvd_error: assert property (REQ0.valid && a0[31:29] == 3'h1
		|=> RSP0.error && RSP0.target == TGT_NONE)
		else $error("reserved access not refused");
	a_sram_half: assert property (ms0 |=> RSP0.byte_en == 4'hF
		&& RSP0.target == ($past(hi0) ? TGT_MSRAM1 : TGT_MSRAM0))
		else $error("main sram block or lanes wrong");
	a_bank_stall: assert property (ms0 && REQ1 == REQ0
		|=> SAME_BANK_STALL && RSP1 == '0)
		else $error("same block collision not stalled");
	a_no_stall: assert property (w0 && !REQ1.valid
		|=> !SAME_BANK_STALL)
		else $error("stall without second request");
	a_straps_frozen: assert property (LOGIC_READY && $past(LOGIC_READY)
		|-> $stable(STRAPS))
		else $error("latched straps changed");
	a_pins_hold: assert property (!EXT_RESET_N [*6]
		|-> $stable(PIN_OUT) && $stable(PIN_OE) && $stable(PIN_PULLUP))
		else $error("pins moved during external reset");
	a_pin_default: assert property (EXT_RESET_N [*6] ##0 PINS_READY
		|-> PIN_OUT == '0 && PIN_OE == '0 && PIN_PULLUP ==
		{{(`NPINS-`NFUSE){1'b0}}, FUSE_CONTROLLED_PULL})
		else $error("pin defaults wrong");
	a_fw_ports: assert property ($stable(FW_MODE)
		|-> LOG_PORT_TEST_EN == (FW_MODE == FW_RADIO_TEST)
		&& LP_PORT_FACTORY_EN == (FW_MODE == FW_FACTORY))
		else $error("serial test enables disagree with mode");
endmodule

bind boot_decode boot_decode_props chk_u (.CLK, .NRST, .EXT_RESET_N,
	.FUSE_CONTROLLED_PULL, .PIN_OUT, .PIN_OE, .PIN_PULLUP, .STRAPS,
	.FW_MODE, .LOG_PORT_TEST_EN, .LP_PORT_FACTORY_EN, .LOGIC_READY,
	.PINS_READY, .REQ0, .REQ1, .RSP0, .RSP1, .SAME_BANK_STALL);
`default_nettype wire

// >>> testbench/tb.sv
// Self-checking bench for boot_decode: straps, firmware mode, decode.
// Assumes the strap_board model and the bound port checker.
`include "boot_defines.svh"
`default_nettype none
module tb
	import boot_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int SUP = 10;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic ext_n = 1'b1;
	logic ble = 1'b0;
	logic [`NPINS-1:0] pin_in = '0;
	logic [`NFUSE-1:0] fuse = '0;
	logic [2:0] gnd = 3'h0;
	logic [3:0] cfg = 4'h0;
	logic [1:0] fw_drv = 2'h0;
	logic [1:0] fw_lvl = 2'h0;
	bus_req_s req0 = '0;
	bus_req_s req1 = '0;
	bus_req_s q0, q1;
	wire logic dl, nsel, sup, fw_pu, log_en, lp_en, lrdy, prdy, stall;
	wire logic [1:0] fw_pins;
	wire logic [`NPINS-1:0] p_out, p_oe, p_pu;
	logic [`NPINS-1:0] p_keep;
	wire strap_s straps;
	wire fw_mode_e fw_mode;
	wire bus_rsp_s rsp0, rsp1;
	int err_count = 0;
	int comparisons = 0;
	integer seed = 95;
	logic [31:0] bases [12] = '{32'h0000_0000, 32'h0002_0000,
		32'h0008_0000, 32'h000C_0000, 32'h01FF_0000, 32'h07FF_0000,
		32'h1000_0000, 32'h1004_0000, 32'h1006_0000, 32'h100E_0000,
		32'h47FF_0000, 32'h57FF_0000};
	bus_req_s corner [11] = '{'{1'b1, 32'h0001_FFFF, 2'h0},
		'{1'b1, 32'h0002_7FFE, 2'h1}, '{1'b1, 32'h0002_8000, 2'h2},
		'{1'b1, 32'h000C_03FC, 2'h2}, '{1'b1, 32'h000C_0400, 2'h2},
		'{1'b1, 32'h0FFF_FFFC, 2'h2}, '{1'b1, 32'h1007_FFFF, 2'h0},
		'{1'b1, 32'h3FFF_FFFC, 2'h2}, '{1'b1, 32'h5000_0001, 2'h1},
		'{1'b1, 32'h4800_0003, 2'h3}, '{1'b1, 32'h100E_0002, 2'h1}};

	always #20 clk = ~clk;

	strap_board brd_u (.clk(clk), .gnd(gnd), .drv(fw_drv), .lvl(fw_lvl),
		.fw_pullup(fw_pu), .download(dl), .normal_sel(nsel),
		.supply_sel(sup), .fw_pins(fw_pins));

	boot_decode #(.SUPPLY_CYC(SUP), .PIN_MIN_CYC(5), .PIN_MAX_CYC(20)) dut_u (
		.CLK(clk), .NRST(nrst), .EXT_RESET_N(ext_n), .PIN_IN(pin_in),
		.DOWNLOAD_STRAP(dl), .NORMAL_SEL_STRAP(nsel),
		.SUPPLY_SELECT_STRAP(sup), .TEST_CONFIG(cfg),
		.FIRMWARE_BOOT_PIN(fw_pins[1]), .FIRMWARE_STATUS_PIN(fw_pins[0]),
		.FUSE_CONTROLLED_PULL(fuse), .BLE_UNUSED(ble), .PIN_OUT(p_out),
		.PIN_OE(p_oe), .PIN_PULLUP(p_pu), .FW_PULLUP(fw_pu),
		.STRAPS(straps), .FW_MODE(fw_mode), .LOG_PORT_TEST_EN(log_en),
		.LP_PORT_FACTORY_EN(lp_en), .LOGIC_READY(lrdy), .PINS_READY(prdy),
		.REQ0(req0), .REQ1(req1), .RSP0(rsp0), .RSP1(rsp1),
		.SAME_BANK_STALL(stall));

	task automatic check(logic [31:0] seen, logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic bus_rsp_s exp_rsp(bus_req_s q, logic b);
		bus_rsp_s r;
		logic [31:0] a;
		r = '0;
		a = q.addr;
		if (a < 32'h0002_0000) r.target = TGT_IROM;
		else if (a < 32'h0002_8000) r.target = TGT_DROM;
		else if (a[31:16] == 16'h0008) r.target = TGT_LSRAM;
		else if (a[31:10] == 22'h000300) r.target = TGT_RET;
		else if (a >= 32'h0200_0000 && a < 32'h0800_0000) r.target = TGT_PSRAM;
		else if (a[31:27] == 5'h01) r.target = TGT_FLASH;
		else if (a[31:19] == 13'h0200) r.target = a[18] ? TGT_MSRAM1 : TGT_MSRAM0;
		else if (a[31:16] == 16'h100E && b) r.target = TGT_EXT0;
		else if (a[31:16] == 16'h100F) r.target = TGT_EXT1;
		else if (a[31:27] == 5'h08) r.target = TGT_PERH;
		else if (a[31:27] == 5'h09) r.target = TGT_PERL;
		else if (a[31:27] == 5'h0A) r.target = TGT_PERS;
		if (q.size == 2'h3 || (q.size == 2'h1 && a[0]) ||
			(q.size == 2'h2 && a[1:0] != 2'h0)) r.target = TGT_NONE;
		r.error = r.target == TGT_NONE;
		if (!r.error) r.byte_en = (q.size == 2'h2 ? 4'hF :
			(q.size == 2'h1 ? 4'h3 : 4'h1)) << a[1:0];
		if (r.target inside {TGT_MSRAM0, TGT_MSRAM1})
			r.pd_hit = a[18] ? (a[17] ? 3'h4 : 3'h2) : 3'h1;
		return r;
	endfunction

	task automatic xfer(bus_req_s r0, bus_req_s r1);
		bus_rsp_s e0, e1;
		logic st;
		e0 = exp_rsp(r0, ble);
		e1 = exp_rsp(r1, ble);
		st = r1.valid && e1.target != TGT_NONE && e1.target == e0.target;
		req0 = r0;
		req1 = r1;
		@(negedge clk);
		check(rsp0, e0);
		check(stall, st);
		if (r1.valid) check(rsp1, st ? 12'h000 : e1);
	endtask

	task automatic boot(int i);
		logic [2:0] g;
		logic [3:0] c;
		logic pu_seen;
		int n;
		fw_mode_e fm;
		g = {i[0] ^ i[1], i[1], i[0]};
		c = 4'($random(seed));
		pu_seen = 1'b0;
		nrst = 1'b0;
		gnd = g;
		cfg = c;
		fw_drv = i == 0 ? 2'h0 : 2'h3;
		fw_lvl = {i == 3, i == 1};
		repeat (4) @(negedge clk);
		nrst = 1'b1;
		repeat (SUP - 1) @(negedge clk);
		check(lrdy, 1'b0);
		n = 0;
		while (fw_mode === FW_NONE && n < 200) begin
			pu_seen |= fw_pu === 1'b1;
			@(negedge clk);
			n++;
		end
		check(pu_seen, 1'b1);
		fm = i == 1 ? FW_RADIO_TEST : (i == 2 ? FW_FACTORY : FW_NORMAL);
		check(fw_mode, fm);
		// Serial enables follow one cycle later; pin ready is already high
		@(negedge clk);
		check({log_en, lp_en}, {i == 1, i == 2});
		check({prdy, lrdy}, 2'h3);
		for (int k = 0; k < 2; k++) begin
			check(straps[7:6], {g[0], g[1]});
			check(straps[1:0], {~g[2], g[2]});
			check(straps.test_cfg, g[1] ? c : 4'h0);
			gnd = ~g;
			cfg = ~c;
			repeat (6) @(negedge clk);
		end
	endtask

	task automatic tally_and_finish();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	initial begin
		repeat (6000) @(posedge clk);
		err_count++;
		tally_and_finish();
	end

	initial begin
		fuse = 5'($random(seed));
		pin_in = 16'($random(seed));
		@(negedge clk);
		for (int i = 0; i < 4; i++) boot(i);
		xfer('{1'b1, 32'h1000_0004, 2'h2}, '{1'b1, 32'h1004_0008, 2'h2});
		xfer('{1'b1, 32'h1000_0010, 2'h2}, '{1'b1, 32'h1000_0010, 2'h2});
		for (int k = 0; k < 22; k++) begin
			ble = k[0];
			xfer(corner[k / 2], '0);
		end
		repeat (80) begin
			ble = 1'($random(seed));
			q0 = '{1'b1, bases[{$random(seed)} % 12] +
				(32'($random(seed)) & 32'h0001_FFFF), 2'($random(seed))};
			q1 = '{1'($random(seed)), bases[{$random(seed)} % 12] +
				(32'($random(seed)) & 32'h0001_FFFF), 2'($random(seed))};
			xfer(q0, q1);
		end
		p_keep = p_pu;
		ext_n = 1'b0;
		repeat (5) @(negedge clk);
		// Move the fuses under the hold: the pins must not follow them
		fuse = ~fuse;
		repeat (5) @(negedge clk);
		check(p_pu, p_keep);
		ext_n = 1'b1;
		repeat (8) @(negedge clk);
		check({p_oe, p_pu}, {{`NPINS{1'b0}}, {(`NPINS-`NFUSE){1'b0}}, fuse});
		check(p_out, 32'h0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
